// [hw/dfpm_pkg.sv]
package dfpm_pkg;

    // ----------------------------------------
    // Bus geometry and register map
    // ----------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int IDX_W = 3;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_PRI_CFG = 4'h1;
    localparam logic [ADDR_W-1:0] REG_SEC_CFG = 4'h2;
    localparam logic [ADDR_W-1:0] REG_PRI_DIV_LO = 4'h3;
    localparam logic [ADDR_W-1:0] REG_PRI_DIV_HI = 4'h4;
    localparam logic [ADDR_W-1:0] REG_SEC_DIV_LO = 4'h5;
    localparam logic [ADDR_W-1:0] REG_SEC_DIV_HI = 4'h6;
    localparam logic [ADDR_W-1:0] REG_TRIM_LO = 4'h7;
    localparam logic [ADDR_W-1:0] REG_TRIM_HI = 4'h8;
    localparam logic [ADDR_W-1:0] REG_FREQ1 = 4'h9;
    localparam logic [ADDR_W-1:0] REG_FREQ2 = 4'ha;
    localparam logic [ADDR_W-1:0] REG_FREQ3 = 4'hb;
    localparam logic [ADDR_W-1:0] REG_PHASE1 = 4'hc;
    localparam logic [ADDR_W-1:0] REG_PHASE2 = 4'hd;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'he;

    // ----------------------------------------
    // Field layouts
    // ----------------------------------------
    typedef enum logic [1:0] {
        LM_DIRECT = 2'h0,
        LM_EIGHT_KHZ_LOCK_MODE = 2'h1,
        LM_DIVIDE = 2'h2,
        LM_RSVD = 2'h3
    } dfpm_lmode_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic [IDX_W-1:0] forceIdx;
        logic forceEn;
        logic srcSel;
        logic measVsPri;
    } dfpm_ctrl_t;

    typedef struct packed {
        logic [3:0] bw;
        logic cleanupPri;
        logic at8k;
        dfpm_lmode_t mode;
    } dfpm_cfg_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic secValid;
        logic priValid;
        dfpm_lmode_t copyMode;
        logic secAt8k;
        logic freeRun;
    } dfpm_status_t;

    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] PRI_CFG_RST = 8'h60;
    localparam logic [DATA_W-1:0] SEC_CFG_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [15:0] TRIM_RST = 16'h0000;
    localparam logic [3:0] PRI_BW_MAX = 4'hc;
    localparam logic [3:0] SEC_BW_MAX = 4'h3;

    // ----------------------------------------
    // Measurement scaling
    // ----------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int PHASE_CORNER_HZ = 100;
    localparam int TWO_PI_E3 = 6283;
    localparam int PHASE_LPF_SH =
        $clog2(CLK_HZ / PHASE_CORNER_HZ * 1000 / TWO_PI_E3);
    localparam int PHASE_STEPS = 512;
    localparam int PHASE_QW = $clog2(PHASE_STEPS);
    localparam int PHASE_W = 16;
    localparam int RATE_OFFSET_READING_W = 24;
    localparam int RATE_OFFSET_READING_RANGE_PPM = 80;
    localparam int RATE_OFFSET_READING_LSB_E7PPM = 3068;
    localparam int RATE_OFFSET_READING_LIMIT = RATE_OFFSET_READING_RANGE_PPM * 10_000_000 / RATE_OFFSET_READING_LSB_E7PPM;
    localparam int INT_FRAC = 8;

endpackage

// [hw/dfpm_edge_div.sv]
`timescale 1ns/1ps
module dfpm_edge_div #(
    parameter int RW = 16
) (
    input wire logic ref_clk, // System clock
    input wire logic rst_n, // Sync reset
    input wire logic clkEn, // State freeze when low
    input wire logic lvl, // Sampled reference level
    input wire logic divOn, // Divide instead of pass
    input wire logic [RW-1:0] ratio, // Edges per output edge
    output logic edgeOut // One-cycle edge pulse
);
    if (RW < 2) begin : g_bad
        $error("RW too small");
    end

    logic prev_r;
    logic [RW-1:0] cnt_r;
    wire rise = lvl & ~prev_r;
    wire [RW-1:0] cntInc = cnt_r + 1'b1;
    // Ratio of zero behaves as one
    wire last = !divOn || (cntInc >= ratio);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // Seeded from the pin, so a high input gives no edge at release
            prev_r <= lvl;
            cnt_r <= '0;
            edgeOut <= 1'b0;
        end else if (clkEn) begin
            prev_r <= lvl;
            edgeOut <= rise && last;
            if (rise) begin
                cnt_r <= last ? '0 : cntInc;
            end
        end
    end
endmodule

// [hw/dfpm_frac_div.sv]
`timescale 1ns/1ps
module dfpm_frac_div #(
    parameter int CW = 20,
    parameter int QW = 9
) (
    input wire logic ref_clk, // System clock
    input wire logic rst_n, // Sync reset
    input wire logic clkEn, // State freeze when low
    input wire logic start, // Begin num/den division
    input wire logic [CW-1:0] num, // Numerator, below den
    input wire logic [CW-1:0] den, // Denominator
    output logic done, // One-cycle result pulse
    output logic [QW-1:0] quot // Fraction num/den in QW bits
);
    if (QW < 2 || CW < 2) begin : g_bad
        $error("bad divider widths");
    end

    logic [CW:0] rem_r;
    logic [CW:0] den_r;
    logic [QW-1:0] q_r;
    logic [$clog2(QW+1)-1:0] cnt_r;
    wire [CW:0] twice = {rem_r[CW-1:0], 1'b0};
    wire ge = twice >= den_r;
    wire busy = cnt_r != '0;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rem_r <= '0;
            den_r <= '0;
            q_r <= '0;
            cnt_r <= '0;
            done <= 1'b0;
            quot <= '0;
        end else if (clkEn) begin
            done <= busy && cnt_r == 1'b1;
            if (busy) begin
                rem_r <= ge ? twice - den_r : twice;
                q_r <= {q_r[QW-2:0], ge};
                cnt_r <= cnt_r - 1'b1;
                if (cnt_r == 1'b1) begin
                    quot <= {q_r[QW-2:0], ge};
                end
            // New starts are dropped while busy
            end else if (start) begin
                rem_r <= {1'b0, num};
                den_r <= {1'b0, den};
                cnt_r <= ($clog2(QW+1))'(QW);
            end
        end
    end
endmodule

// [hw/dfpm_top.sv]
// What this block does
// - Setting measure-vs-primary puts the secondary loop into free-run.
// - In that mode secondary locking stops; detector compares both selected references.
// - Software may force any input to be the secondary selected reference.
// - Frequency reading over three registers follows the measurement source select.
// - Frequency step 0.0003068 ppm, clamped to plus or minus 80 ppm.
// - Frequency reading is the integral path, averaging inversely with bandwidth.
// - Phase reading over two registers follows the same source select.
// - Phase step about 0.703 degrees, low-pass averaged near 61 Hz.
// - Primary phase is always selected reference against its feedback clock.
// - Copy of primary reference is divided to 8 kHz when secondary is, except when primary is in divide mode with its 8 kHz flag clear.
// - Primary loop keeps locking per its own input configuration meanwhile.
// - Copy lock mode is chosen from both loops' modes per fixed table.
// - Frequency is referenced to the oscillator corrected by master clock trim.
// - Secondary cleanup PLL stays usable on primary-derived clock in this mode.
// - Primary bandwidth selectable among thirteen settings, 0.1 Hz to 400 Hz.
// - Secondary bandwidth selectable among several settings, 18 Hz to 70 Hz.
`timescale 1ns/1ps
module dfpm_top #(
    parameter int N_REF = 8,
    parameter int CW = 20
) (
    input wire logic ref_clk, // 200 MHz master clock
    input wire logic rst_n, // Sync reset
    input wire logic clkEn, // State freeze when low
    input wire logic [N_REF-1:0] refIn, // Input reference levels
    input wire logic [dfpm_pkg::IDX_W-1:0] priSelIdx, // Primary selected input
    input wire logic [dfpm_pkg::IDX_W-1:0] secAutoIdx, // Secondary auto choice
    input wire logic priFbEdge, // Primary feedback edge pulse
    input wire logic secFbEdge, // Secondary feedback edge pulse
    input wire logic [dfpm_pkg::ADDR_W-1:0] addr, // Register address
    input wire logic [dfpm_pkg::DATA_W-1:0] wrData, // Write data
    input wire logic wrEn, // Write strobe
    input wire logic rdEn, // Read strobe
    output logic [dfpm_pkg::DATA_W-1:0] rdData, // Read data, next cycle
    output logic secFreeRun, // Secondary in free-run
    output logic cleanupSrcPri, // Secondary cleanup PLL fed by primary
    output logic [dfpm_pkg::IDX_W-1:0] secSelIdx // Secondary selected input
);
    if (N_REF < 2 || N_REF > (1 << dfpm_pkg::IDX_W) || CW < 8) begin : g_bad
        $error("N_REF or CW out of range");
    end

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    dfpm_pkg::dfpm_ctrl_t ctrl_r;
    dfpm_pkg::dfpm_cfg_t priCfg_r;
    dfpm_pkg::dfpm_cfg_t secCfg_r;
    logic [15:0] priDiv_r;
    logic [15:0] secDiv_r;
    logic [15:0] trim_r;
    logic [15:0] freqHold_r;
    logic [7:0] phaseHold_r;

    wire wrCtrl = wrEn && addr == dfpm_pkg::REG_CTRL;
    wire wrPriCfg = wrEn && addr == dfpm_pkg::REG_PRI_CFG;
    wire wrSecCfg = wrEn && addr == dfpm_pkg::REG_SEC_CFG;
    wire wrPriLo = wrEn && addr == dfpm_pkg::REG_PRI_DIV_LO;
    wire wrPriHi = wrEn && addr == dfpm_pkg::REG_PRI_DIV_HI;
    wire wrSecLo = wrEn && addr == dfpm_pkg::REG_SEC_DIV_LO;
    wire wrSecHi = wrEn && addr == dfpm_pkg::REG_SEC_DIV_HI;
    wire wrTrimLo = wrEn && addr == dfpm_pkg::REG_TRIM_LO;
    wire wrTrimHi = wrEn && addr == dfpm_pkg::REG_TRIM_HI;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r <= dfpm_pkg::CTRL_RST;
            priCfg_r <= dfpm_pkg::PRI_CFG_RST;
            secCfg_r <= dfpm_pkg::SEC_CFG_RST;
        end else if (clkEn) begin
            if (wrCtrl) begin
                ctrl_r <= wrData;
            end
            if (wrPriCfg) begin
                priCfg_r <= wrData;
            end
            if (wrSecCfg) begin
                secCfg_r <= wrData;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            priDiv_r <= dfpm_pkg::DIV_RST;
            secDiv_r <= dfpm_pkg::DIV_RST;
            trim_r <= dfpm_pkg::TRIM_RST;
        end else if (clkEn) begin
            if (wrPriLo) begin
                priDiv_r[7:0] <= wrData;
            end
            if (wrPriHi) begin
                priDiv_r[15:8] <= wrData;
            end
            if (wrSecLo) begin
                secDiv_r[7:0] <= wrData;
            end
            if (wrSecHi) begin
                secDiv_r[15:8] <= wrData;
            end
            if (wrTrimLo) begin
                trim_r[7:0] <= wrData;
            end
            if (wrTrimHi) begin
                trim_r[15:8] <= wrData;
            end
        end
    end

    // ----------------------------------------
    // Secondary loop state
    // ----------------------------------------
    typedef enum logic {
        SEC_TRACK,
        SEC_FREERUN
    } dfpm_secst_t;

    dfpm_secst_t secState_r;
    dfpm_secst_t secState_nxt;

    always_comb begin
        case (secState_r)
            SEC_TRACK: secState_nxt = ctrl_r.measVsPri ? SEC_FREERUN : SEC_TRACK;
            SEC_FREERUN: secState_nxt = ctrl_r.measVsPri ? SEC_FREERUN : SEC_TRACK;
            default: secState_nxt = SEC_TRACK;
        endcase
    end

    wire measMode = secState_r == SEC_FREERUN;

    wire [dfpm_pkg::IDX_W-1:0] secIdxNxt = ctrl_r.forceEn ? ctrl_r.forceIdx : secAutoIdx;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            secState_r <= SEC_TRACK;
            secFreeRun <= 1'b0;
            cleanupSrcPri <= 1'b0;
            secSelIdx <= '0;
        end else if (clkEn) begin
            secState_r <= secState_nxt;
            secFreeRun <= secState_nxt == SEC_FREERUN;
            cleanupSrcPri <= secCfg_r.cleanupPri;
            secSelIdx <= secIdxNxt;
        end
    end

    // ----------------------------------------
    // Reference paths and copy adaptation
    // ----------------------------------------
    wire priLvl = (int'(priSelIdx) < N_REF) ? refIn[priSelIdx] : 1'b0;
    wire secLvl = (int'(secSelIdx) < N_REF) ? refIn[secSelIdx] : 1'b0;

    wire secAt8k = secCfg_r.mode == dfpm_pkg::LM_EIGHT_KHZ_LOCK_MODE
        || (secCfg_r.mode == dfpm_pkg::LM_DIVIDE && secCfg_r.at8k);
    wire priDivide = priCfg_r.mode == dfpm_pkg::LM_DIVIDE;

    // copy follows secondary to 8 kHz unless primary divides with at8k clear
    wire dfpm_pkg::dfpm_lmode_t copyMode = !secAt8k ? dfpm_pkg::LM_DIRECT
        : priDivide ? (priCfg_r.at8k ? dfpm_pkg::LM_DIVIDE : dfpm_pkg::LM_DIRECT)
        : dfpm_pkg::LM_EIGHT_KHZ_LOCK_MODE;
    wire copyDivOn = copyMode != dfpm_pkg::LM_DIRECT;
    // primary path unaffected by measure mode
    wire priDivOn = priCfg_r.mode == dfpm_pkg::LM_EIGHT_KHZ_LOCK_MODE || priDivide;
    wire secDivOn = secCfg_r.mode == dfpm_pkg::LM_EIGHT_KHZ_LOCK_MODE
        || secCfg_r.mode == dfpm_pkg::LM_DIVIDE;

    logic priRefEdge;
    logic copyEdge;
    logic secRefEdge;

    dfpm_edge_div #(.RW(16)) uPriEdge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .lvl(priLvl),
        .divOn(priDivOn),
        .ratio(priDiv_r),
        .edgeOut(priRefEdge)
    );

    dfpm_edge_div #(.RW(16)) uCopyEdge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .lvl(priLvl),
        .divOn(copyDivOn),
        .ratio(priDiv_r),
        .edgeOut(copyEdge)
    );

    dfpm_edge_div #(.RW(16)) uSecEdge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .lvl(secLvl),
        .divOn(secDivOn),
        .ratio(secDiv_r),
        .edgeOut(secRefEdge)
    );

    // ----------------------------------------
    // Phase detectors, averaging, integrals
    // ----------------------------------------
    localparam int SH = dfpm_pkg::PHASE_LPF_SH;
    localparam int QW = dfpm_pkg::PHASE_QW;
    localparam int PW = dfpm_pkg::PHASE_W;
    localparam int IW = dfpm_pkg::RATE_OFFSET_READING_W + dfpm_pkg::INT_FRAC;
    localparam logic signed [IW:0] INT_LIM =
        (IW+1)'(dfpm_pkg::RATE_OFFSET_READING_LIMIT) <<< dfpm_pkg::INT_FRAC;

    wire [3:0] priBw = (priCfg_r.bw > dfpm_pkg::PRI_BW_MAX) ? dfpm_pkg::PRI_BW_MAX
        : priCfg_r.bw;
    wire [3:0] secBw = (secCfg_r.bw > dfpm_pkg::SEC_BW_MAX) ? dfpm_pkg::SEC_BW_MAX
        : secCfg_r.bw;

    logic [1:0] refE;
    logic [1:0] cmpE;
    logic [1:0] hold;
    logic [3:0] gain [2];
    logic [1:0] valid;
    logic signed [PW-1:0] phaseAvg [2];
    logic signed [IW-1:0] integ [2];

    assign refE[0] = priRefEdge;
    assign cmpE[0] = priFbEdge;
    assign hold[0] = 1'b0;
    assign gain[0] = priBw;
    // in measure mode secondary compares copy with its reference
    assign refE[1] = secRefEdge;
    assign cmpE[1] = measMode ? copyEdge : secFbEdge;
    assign hold[1] = measMode;
    assign gain[1] = secBw;

    for (genvar k = 0; k < 2; k++) begin : g_loop
        logic [CW-1:0] since_r;
        logic [CW-1:0] period_r;
        logic valid_r;
        logic signed [QW-1:0] sample_r;
        logic signed [PW+SH-1:0] acc_r;
        logic signed [IW-1:0] int_r;
        logic done;
        logic [QW-1:0] quot;

        wire [CW-1:0] sinceInc = (since_r == '1) ? since_r : since_r + 1'b1;
        wire startDiv = cmpE[k] && valid_r && since_r < period_r;
        // Wrapped fraction of a cycle, step 360/512 degrees
        wire signed [QW-1:0] phaseNow = quot;
        wire signed [PW+SH-1:0] accStep =
            (((PW+SH)'(sample_r) <<< SH) - acc_r) >>> SH;
        wire signed [IW:0] intSum =
            (IW+1)'(int_r) + ((IW+1)'(phaseNow) <<< gain[k]);
        wire signed [IW:0] intSat = (intSum > INT_LIM) ? INT_LIM
            : (intSum < -INT_LIM) ? -INT_LIM : intSum;

        dfpm_frac_div #(.CW(CW), .QW(QW)) uDiv (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .clkEn(clkEn),
            .start(startDiv),
            .num(since_r),
            .den(period_r),
            .done(done),
            .quot(quot)
        );

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                since_r <= '0;
                period_r <= '0;
                valid_r <= 1'b0;
            end else if (clkEn) begin
                since_r <= refE[k] ? '0 : sinceInc;
                if (refE[k]) begin
                    period_r <= sinceInc;
                    valid_r <= 1'b1;
                end
            end
        end

        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                sample_r <= '0;
                acc_r <= '0;
            end else if (clkEn) begin
                acc_r <= acc_r + accStep;
                if (done) begin
                    sample_r <= phaseNow;
                end
            end
        end

        // integral saturates at the range limit
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                int_r <= '0;
            end else if (clkEn) begin
                if (hold[k]) begin
                    int_r <= '0;
                end else if (done) begin
                    int_r <= intSat[IW-1:0];
                end
            end
        end

        assign phaseAvg[k] = acc_r[PW+SH-1:SH];
        assign integ[k] = int_r;
        assign valid[k] = valid_r;
    end

    // ----------------------------------------
    // Readings
    // ----------------------------------------
    localparam int FW = dfpm_pkg::RATE_OFFSET_READING_W;
    localparam logic signed [FW+1:0] F_LIM = (FW+2)'(dfpm_pkg::RATE_OFFSET_READING_LIMIT);

    wire signed [IW-1:0] integSel = ctrl_r.srcSel ? integ[1] : integ[0];
    wire signed [FW+1:0] freqSum = (FW+2)'(integSel >>> dfpm_pkg::INT_FRAC)
        + (FW+2)'($signed(trim_r));
    wire signed [FW+1:0] freqSat = (freqSum > F_LIM) ? F_LIM
        : (freqSum < -F_LIM) ? -F_LIM : freqSum;
    wire [FW-1:0] freqNow = freqSat[FW-1:0];
    wire [PW-1:0] phaseNowSel = ctrl_r.srcSel ? phaseAvg[1] : phaseAvg[0];

    dfpm_pkg::dfpm_status_t status;
    assign status = '{rsvd: 2'h0, secValid: valid[1], priValid: valid[0],
        copyMode: copyMode, secAt8k: secAt8k, freeRun: measMode};

    logic [dfpm_pkg::DATA_W-1:0] rdMux;
    always_comb begin
        case (addr)
            dfpm_pkg::REG_CTRL: rdMux = ctrl_r;
            dfpm_pkg::REG_PRI_CFG: rdMux = priCfg_r;
            dfpm_pkg::REG_SEC_CFG: rdMux = secCfg_r;
            dfpm_pkg::REG_PRI_DIV_LO: rdMux = priDiv_r[7:0];
            dfpm_pkg::REG_PRI_DIV_HI: rdMux = priDiv_r[15:8];
            dfpm_pkg::REG_SEC_DIV_LO: rdMux = secDiv_r[7:0];
            dfpm_pkg::REG_SEC_DIV_HI: rdMux = secDiv_r[15:8];
            dfpm_pkg::REG_TRIM_LO: rdMux = trim_r[7:0];
            dfpm_pkg::REG_TRIM_HI: rdMux = trim_r[15:8];
            dfpm_pkg::REG_FREQ1: rdMux = freqNow[7:0];
            dfpm_pkg::REG_FREQ2: rdMux = freqHold_r[7:0];
            dfpm_pkg::REG_FREQ3: rdMux = freqHold_r[15:8];
            dfpm_pkg::REG_PHASE1: rdMux = phaseNowSel[7:0];
            dfpm_pkg::REG_PHASE2: rdMux = phaseHold_r;
            dfpm_pkg::REG_STATUS: rdMux = status;
            default: rdMux = '0;
        endcase
    end

    // Low byte read freezes the upper bytes, so multi-byte reads never tear
    wire rdFreqLo = rdEn && addr == dfpm_pkg::REG_FREQ1;
    wire rdPhaseLo = rdEn && addr == dfpm_pkg::REG_PHASE1;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdData <= '0;
            freqHold_r <= '0;
            phaseHold_r <= '0;
        end else if (clkEn) begin
            rdData <= rdEn ? rdMux : '0;
            if (rdFreqLo) begin
                freqHold_r <= freqNow[23:8];
            end
            if (rdPhaseLo) begin
                phaseHold_r <= phaseNowSel[15:8];
            end
        end
    end
endmodule

// [sim/dfpm_top_sva.sv]
`timescale 1ns/1ps
module dfpm_top_sva (
    input wire logic ref_clk, // Clock
    input wire logic rst_n, // Sync reset
    input wire logic clkEn, // Freeze when low
    input wire logic [dfpm_pkg::ADDR_W-1:0] addr, // Address
    input wire logic [dfpm_pkg::DATA_W-1:0] wrData, // Write data
    input wire logic wrEn, // Write strobe
    input wire logic rdEn, // Read strobe
    input wire logic [dfpm_pkg::DATA_W-1:0] rdData, // Read data
    input wire logic secFreeRun, // Free-run flag
    input wire logic cleanupSrcPri, // Cleanup source
    input wire logic [dfpm_pkg::IDX_W-1:0] secAutoIdx, // Auto choice
    input wire logic [dfpm_pkg::IDX_W-1:0] secSelIdx // Selected input
);
    wire ctrlWr = clkEn && wrEn && addr == dfpm_pkg::REG_CTRL;
    wire secWr = clkEn && wrEn && addr == dfpm_pkg::REG_SEC_CFG;
    wire trimWr = clkEn && wrEn && addr == dfpm_pkg::REG_TRIM_LO;
    wire trimRd = clkEn && rdEn && addr == dfpm_pkg::REG_TRIM_LO;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_free_run_set: assert property (ctrlWr ##1 clkEn |=>
        secFreeRun == $past(wrData[0], 2)) else $error("free-run flag wrong");
    a_free_run_hold: assert property ($changed(secFreeRun) |->
        $past(ctrlWr, 2)) else $error("free-run flag moved alone");
    a_rd_idle: assert property ((clkEn && !rdEn) |=> rdData == 8'h00)
        else $error("read data not idle");
    a_rd_unmapped: assert property ((clkEn && rdEn && addr == 4'hf) |=>
        rdData == 8'h00) else $error("unmapped read not zero");
    a_force_sel: assert property (ctrlWr && wrData[2] ##1 clkEn && !ctrlWr |=>
        secSelIdx == $past(wrData[5:3], 2)) else $error("forced input wrong");
    a_sel_cause: assert property ($changed(secSelIdx) |-> $past(ctrlWr, 2) ||
        $past(secAutoIdx, 1) != $past(secAutoIdx, 2)) else $error("selection moved");
    a_cleanup_copy: assert property (secWr ##1 clkEn |=>
        cleanupSrcPri == $past(wrData[3], 2)) else $error("cleanup source wrong");
    a_trim_back: assert property (trimWr ##1 !wrEn ##1 trimRd |=>
        rdData == $past(wrData, 3)) else $error("trim readback wrong");
endmodule

bind dfpm_top dfpm_top_sva chk (.ref_clk, .rst_n, .clkEn, .addr, .wrData, .wrEn,
    .rdEn, .rdData, .secFreeRun, .cleanupSrcPri, .secAutoIdx, .secSelIdx);

// [sim/dfpm_ref_model.sv]
`timescale 1ns/1ps
module dfpm_ref_model #(
    parameter int N_REF = 8,
    parameter int HALF = 20
) (
    input wire logic ref_clk, // Clock
    output logic [N_REF-1:0] refIn, // Reference levels
    output logic fbEdge // Feedback pulse
);
    logic [15:0] tick = 16'h0000;
    always @(posedge ref_clk) begin
        tick <= tick + 16'h0001;
    end
    for (genvar i = 0; i < N_REF; i++) begin : g_ref
        assign refIn[i] = ((int'(tick) + i * 3) / HALF) % 2 == 1;
    end
    assign fbEdge = int'(tick) % (2 * HALF) == 3;
endmodule

// [sim/test_dfpm_top.sv]
`timescale 1ns/1ps
module test_dfpm_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wrData = 8'h00;
    logic [7:0] rdData;
    logic [7:0] refIn;
    logic priFbEdge;
    logic [2:0] secAutoIdx = 3'h0;
    logic [2:0] secSelIdx;
    logic secFreeRun;
    logic cleanupSrcPri;
    int n_fail = 0;
    int checks = 0;
    logic [7:0] secTab [6] = '{8'h05, 8'h06, 8'h05, 8'h05, 8'h02, 8'h00};
    logic [7:0] priTab [6] = '{8'h00, 8'h05, 8'h06, 8'h02, 8'h05, 8'h06};
    logic [7:0] expTab [6] = '{8'h07, 8'h07, 8'h0b, 8'h03, 8'h01, 8'h01};
    always #2.5 ref_clk = ~ref_clk;
    dfpm_ref_model refs (.ref_clk, .refIn, .fbEdge(priFbEdge));
    dfpm_top uut (.ref_clk, .rst_n, .clkEn(1'b1), .refIn, .priSelIdx(3'h1),
        .secAutoIdx, .priFbEdge, .secFbEdge(1'b0), .addr, .wrData, .wrEn, .rdEn,
        .rdData, .secFreeRun, .cleanupSrcPri, .secSelIdx);
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge ref_clk);
        wrEn <= 1'b0;
    endtask
    task rdc(input logic [3:0] a, input logic [7:0] e, input string w,
        input logic [7:0] m = 8'hff);
        @(posedge ref_clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge ref_clk);
        rdEn <= 1'b0;
        @(negedge ref_clk);
        chk(w, rdData & m, e);
    endtask
    task settle;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdc(4'h0, 8'h00, "ctrl");
        rdc(4'h1, 8'h60, "primary cfg");
        rdc(4'h3, 8'h01, "primary div");
        rdc(4'hf, 8'h00, "unmapped");
        wr(4'he, 8'hff);
        rdc(4'he, 8'h00, "status", 8'h0f);
        wr(4'h0, 8'h01);
        settle;
        chk("free run", {7'h0, secFreeRun}, 8'h01);
        for (int i = 0; i < 6; i++) begin
            wr(4'h2, secTab[i]);
            wr(4'h1, priTab[i]);
            settle;
            rdc(4'he, expTab[i], "copy mode", 8'h0f);
        end
        for (int i = 0; i < 8; i++) begin
            wr(4'h0, {2'b00, 3'(i), 3'b101});
            settle;
            chk("forced input", {5'h0, secSelIdx}, 8'(i));
        end
        @(posedge ref_clk) secAutoIdx <= 3'h3;
        wr(4'h0, 8'h01);
        settle;
        chk("auto input", {5'h0, secSelIdx}, 8'h03);
        wr(4'h2, 8'h08);
        settle;
        chk("cleanup", {7'h0, cleanupSrcPri}, 8'h01);
        wr(4'h0, 8'h03);
        wr(4'h7, 8'h05);
        rdc(4'h7, 8'h05, "trim");
        settle;
        rdc(4'h9, 8'h05, "rate_offset_reading low");
        rdc(4'ha, 8'h00, "rate_offset_reading mid");
        rdc(4'hb, 8'h00, "rate_offset_reading high");
        wr(4'h7, 8'hff);
        wr(4'h8, 8'hff);
        wr(4'h9, 8'haa);
        settle;
        rdc(4'h9, 8'hff, "rate_offset_reading low");
        rdc(4'ha, 8'hff, "rate_offset_reading mid");
        rdc(4'hb, 8'hff, "rate_offset_reading high");
        // Primary lags by about 0.6 cycle, so its integral saturates negative
        wr(4'h1, 8'hf0);
        wr(4'h0, 8'h01);
        repeat (250) settle;
        rdc(4'h9, 8'h6c, "primary rate_offset_reading low");
        rdc(4'ha, 8'h05, "primary rate_offset_reading mid");
        rdc(4'hb, 8'hfc, "primary rate_offset_reading high");
        rdc(4'hc, 8'h80, "phase low", 8'h80);
        rdc(4'hd, 8'hff, "phase high");
        summarize;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        summarize;
    end
endmodule
